// File: core/vmr_entry_lookup.sv
// Selects the 16-bit physical entry for a virtual identifier held in registers 5 to 7
`timescale 1ns/1ps
module vmr_entry_lookup
  import vmr_pkg::*;
(
  input wire logic [VMR_NUM_REGS-1:0][VMR_REG_W-1:0] regs,
  input wire logic [VMR_VID_W-1:0] vid,
  output logic in_range,
  output logic [VMR_ENTRY_W-1:0] entry
);

  logic [VMR_VID_W-1:0] reg_num;
  logic [1:0] slot;
  logic [VMR_REG_W-1:0] word;

  // ****************************************************************
  // Entry select
  // ****************************************************************
  // Entry m lives in register m >> 2, slot m[1:0], lowest id in lowest field
  always_comb begin
    reg_num = vid >> 2;
    slot = vid[1:0];
    in_range = (reg_num >= 16'(VMR_FIRST_REG)) &&
               (reg_num < 16'(VMR_FIRST_REG + VMR_NUM_REGS));
    word = '0;
    if (in_range) begin
      word = regs[2'(reg_num - 16'(VMR_FIRST_REG))];
    end
    entry = word[slot*VMR_ENTRY_W +: VMR_ENTRY_W];
  end

endmodule : vmr_entry_lookup

// File: core/vmr_sysreg_decode.sv
// Encoding match and presence decode for mapping registers 5 to 7
`timescale 1ns/1ps
module vmr_sysreg_decode
  import vmr_pkg::*;
(
  input wire vmr_enc_t enc,
  input wire logic [2:0] vmap_max,
  input wire logic partitioning_present,
  input wire logic has_hyp_control,
  output logic hit,
  output logic present,
  output logic [1:0] idx
);

  logic [VMR_NUM_REGS-1:0] match;
  logic [VMR_NUM_REGS-1:0] exists;
  logic common_ok;

  // ****************************************************************
  // Per-register match
  // ****************************************************************
  // Only op2 differs between the three registers
  assign common_ok = (enc.op0 == VMR_ENC_OP0) && (enc.op1 == VMR_ENC_OP1) &&
                     (enc.crn == VMR_ENC_CRN) && (enc.crm == VMR_ENC_CRM);

  for (genvar i = 0; i < VMR_NUM_REGS; i++) begin : g_reg
    localparam logic [2:0] OP2 = (i == 0) ? VMR_ENC_OP2_REG5 :
                                 (i == 1) ? VMR_ENC_OP2_REG6 : VMR_ENC_OP2_REG7;
    localparam logic [2:0] REG_NUM = 3'(VMR_FIRST_REG + i);
    assign match[i] = common_ok && (enc.op2 == OP2);
    // Register n exists when partitioning and hypervisor control are present and the highest index reaches n; index 0 means none
    assign exists[i] = partitioning_present && has_hyp_control &&
                       (vmap_max >= REG_NUM);
  end

  // Result for whichever register matched
  always_comb begin
    hit = |match;
    present = |(match & exists);
    idx = 2'h0;
    if (match[1]) begin
      idx = 2'h1;
    end else if (match[2]) begin
      idx = 2'h2;
    end
  end

endmodule : vmr_sysreg_decode

// File: core/vmr_vmap_regs.sv
// Virtual partition map registers 5 to 7 with privilege-checked access and lookup
`timescale 1ns/1ps
module vmr_vmap_regs
  import vmr_pkg::*;
#(
  parameter logic [2:0] VMAP_MAX = VMR_VMAP_MAX_RESET
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire vmr_req_t req,
  input wire vmr_ctrl_t ctrl,
  input wire logic kernel_vmap_enable,
  input wire logic user_vmap_enable,
  input wire logic [VMR_VALID_W-1:0] vmap_valid_bits,
  input wire logic xl_valid,
  input wire logic xl_from_user,
  input wire logic [VMR_VID_W-1:0] xl_vid,
  output vmr_rsp_t rsp,
  output logic [2:0] highest_vmap_index,
  output logic xl_out_valid,
  output logic xl_mapped,
  output logic [VMR_VID_W-1:0] xl_pid
);

  // ****************************************************************
  // Storage and output registers
  // ****************************************************************
  logic [VMR_NUM_REGS-1:0][VMR_REG_W-1:0] vmap_q;
  vmr_rsp_t rsp_q;
  vmr_rsp_t rsp_d;
  logic [2:0] vmap_max_q;
  logic xl_out_valid_q;
  logic xl_mapped_q;
  logic xl_mapped_d;
  logic [VMR_VID_W-1:0] xl_pid_q;
  logic [VMR_VID_W-1:0] xl_pid_d;

  // Decode results
  logic acc_hit;
  logic acc_present;
  logic [1:0] acc_idx;
  logic acc_do_reg;
  logic monitor_traps;
  logic [11:0] save_ofs;

  // Lookup results
  logic lk_in_range;
  logic [VMR_ENTRY_W-1:0] lk_entry;
  logic lk_enable;
  logic lk_valid;

  assign rsp = rsp_q;
  assign highest_vmap_index = vmap_max_q;
  assign xl_out_valid = xl_out_valid_q;
  assign xl_mapped = xl_mapped_q;
  assign xl_pid = xl_pid_q;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  vmr_sysreg_decode u_decode (
    .enc(req.enc),
    .vmap_max(vmap_max_q),
    .partitioning_present(ctrl.partitioning_present),
    .has_hyp_control(ctrl.has_hyp_control),
    .hit(acc_hit),
    .present(acc_present),
    .idx(acc_idx)
  );

  // Monitor traps only exist when the monitor level itself exists
  assign monitor_traps = ctrl.monitor_present && ctrl.trap_lower_levels;

  // Save-area slot for the redirected access
  always_comb begin
    unique case (acc_idx)
      2'h0: save_ofs = VMR_SAVE_OFS_REG5;
      2'h1: save_ofs = VMR_SAVE_OFS_REG6;
      default: save_ofs = VMR_SAVE_OFS_REG7;
    endcase
  end

  // Outcome of one access; an absent register is undefined at every level
  always_comb begin
    rsp_d = '0;
    acc_do_reg = 1'b0;
    // Idle cycles leave every field at zero so a stale level never looks like an answer
    if (req.valid && acc_hit) begin
      rsp_d.valid = 1'b1;
      rsp_d.write = req.write;
      rsp_d.kind = VMR_RSP_UNDEF;
      rsp_d.target = req.level;
    end
    if (req.valid && acc_hit && acc_present) begin
      unique case (req.level)
        VMR_LVL_USER: begin
          rsp_d.kind = VMR_RSP_UNDEF;
        end
        VMR_LVL_KERNEL: begin
          if (ctrl.el2_enabled && ctrl.nested_virt && ctrl.nested_virt_mem) begin
            rsp_d.kind = VMR_RSP_SAVE;
            rsp_d.save_offset = save_ofs;
          end else if (ctrl.el2_enabled && ctrl.nested_virt) begin
            rsp_d.kind = VMR_RSP_TRAP;
            rsp_d.trap_class = VMR_TRAP_CLASS;
            rsp_d.target = monitor_traps ? VMR_LVL_MONITOR : VMR_LVL_HYP;
          end else begin
            rsp_d.kind = VMR_RSP_UNDEF;
          end
        end
        VMR_LVL_HYP: begin
          if (monitor_traps) begin
            rsp_d.kind = VMR_RSP_TRAP;
            rsp_d.trap_class = VMR_TRAP_CLASS;
            rsp_d.target = VMR_LVL_MONITOR;
          end else begin
            rsp_d.kind = VMR_RSP_DONE;
            acc_do_reg = 1'b1;
          end
        end
        VMR_LVL_MONITOR: begin
          rsp_d.kind = VMR_RSP_DONE;
          acc_do_reg = 1'b1;
        end
      endcase
    end
    // Read data is only returned for a completed read; everything else shows zero
    if (acc_do_reg && !req.write) begin
      rsp_d.rdata = vmap_q[acc_idx];
    end
  end

  // Response register, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // Identification field is captured after reset, so the strap never feeds reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vmap_max_q <= VMR_VMAP_MAX_RESET;
    end else begin
      vmap_max_q <= VMAP_MAX;
    end
  end

  // ****************************************************************
  // Mapping storage
  // ****************************************************************
  // No reset: fields are unknown until software programs them, which saves
  // reset fan-out on 192 flops
  for (genvar i = 0; i < VMR_NUM_REGS; i++) begin : g_store
    always_ff @(posedge clk) begin
      if (req.valid && acc_hit && acc_present && acc_do_reg && req.write &&
          (acc_idx == 2'(i))) begin
        vmap_q[i] <= req.wdata;
      end
    end
  end

  // ****************************************************************
  // Identifier translation
  // ****************************************************************
  vmr_entry_lookup u_lookup (
    .regs(vmap_q),
    .vid(xl_vid),
    .in_range(lk_in_range),
    .entry(lk_entry)
  );

  // Enable follows the source register; nothing maps while the hypervisor is off
  assign lk_enable = ctrl.el2_enabled && ctrl.partitioning_present &&
                     ctrl.has_hyp_control && (vmap_max_q >= 3'h5) &&
                     (xl_from_user ? user_vmap_enable : kernel_vmap_enable);

  // Valid bit m gates entry m; an invalid entry falls back to the virtual id
  assign lk_valid = lk_in_range && vmap_valid_bits[xl_vid[4:0]];

  always_comb begin
    xl_mapped_d = xl_valid && lk_enable && lk_valid;
    xl_pid_d = xl_mapped_d ? lk_entry : xl_vid;
    // Register 6 and 7 entries only map when those registers exist
    if (xl_mapped_d && (xl_vid[4:2] > vmap_max_q)) begin
      xl_mapped_d = 1'b0;
      xl_pid_d = xl_vid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xl_out_valid_q <= 1'b0;
      xl_mapped_q <= 1'b0;
      xl_pid_q <= '0;
    end else begin
      xl_out_valid_q <= xl_valid;
      xl_mapped_q <= xl_mapped_d;
      xl_pid_q <= xl_pid_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_user_level_undef:
    assert property (req.valid && acc_hit && req.level == VMR_LVL_USER
                     |=> rsp.valid && rsp.kind == VMR_RSP_UNDEF)
    else $error("user level access not undefined");

  a_kernel_plain_undef:
    assert property (req.valid && acc_hit && req.level == VMR_LVL_KERNEL &&
                     !ctrl.nested_virt |=> rsp.kind == VMR_RSP_UNDEF)
    else $error("kernel access without nested_virt not undefined");

  a_save_redirect_ofs:
    assert property (req.valid && acc_hit && acc_present && req.level == VMR_LVL_KERNEL &&
                     ctrl.el2_enabled && ctrl.nested_virt && ctrl.nested_virt_mem
                     |=> rsp.kind == VMR_RSP_SAVE &&
                         rsp.save_offset == 12'h968 + 12'($past(acc_idx)) * 12'h8)
    else $error("save area redirection wrong");

  a_kernel_trap_target:
    assert property (req.valid && acc_hit && acc_present && req.level == VMR_LVL_KERNEL &&
                     ctrl.el2_enabled && ctrl.nested_virt && !ctrl.nested_virt_mem
                     |=> rsp.kind == VMR_RSP_TRAP && rsp.trap_class == 6'h18 &&
                         rsp.target == ($past(monitor_traps) ? VMR_LVL_MONITOR : VMR_LVL_HYP))
    else $error("kernel trap wrong");

  a_hyp_trap_monitor:
    assert property (req.valid && acc_hit && acc_present && req.level == VMR_LVL_HYP
                     |=> (rsp.kind == VMR_RSP_TRAP) == $past(monitor_traps))
    else $error("hypervisor access trap decision wrong");

  a_monitor_direct:
    assert property (req.valid && acc_hit && acc_present && req.level == VMR_LVL_MONITOR
                     |=> rsp.valid && rsp.kind == VMR_RSP_DONE)
    else $error("monitor access not performed");

  a_absent_reg_undef:
    assert property (req.valid && acc_hit && req.enc.op2 == 3'h7 && vmap_max_q != 3'h7
                     |=> rsp.kind == VMR_RSP_UNDEF)
    else $error("absent register 7 not undefined");

  a_read_last_write:
    assert property (req.valid && acc_hit && acc_do_reg && req.write ##1
                     (req.valid && acc_hit && acc_do_reg && !req.write &&
                      acc_idx == $past(acc_idx))
                     |=> rsp.rdata == $past(req.wdata, 2))
    else $error("read does not return last write");

  a_map_gated_enable:
    assert property (xl_valid && (!ctrl.el2_enabled ||
                     (xl_from_user ? !user_vmap_enable : !kernel_vmap_enable))
                     |=> !xl_mapped && xl_pid == $past(xl_vid))
    else $error("mapping applied while disabled");

  a_invalid_entry:
    assert property (xl_valid && !vmap_valid_bits[xl_vid[4:0]] |=> !xl_mapped)
    else $error("invalid entry used for translation");

  a_entry23_field:
    assert property (xl_valid && xl_vid == 16'h0017 && lk_enable && vmap_valid_bits[23]
                     |=> xl_mapped && xl_pid == $past(vmap_q[0][63:48]))
    else $error("entry 23 not taken from top field");

  a_idle_rsp_zero:
    assert property (!(req.valid && acc_hit) |=> rsp == '0)
    else $error("response fields set without a taken request");

  a_reg6_absent_undef:
    assert property (req.valid && acc_hit && req.enc.op2 == 3'h6 && vmap_max_q < 3'h6
                     |=> rsp.valid && rsp.kind == VMR_RSP_UNDEF)
    else $error("absent register 6 not undefined");

  a_zero_index_none:
    assert property (req.valid && acc_hit && vmap_max_q == 3'h0 |=> rsp.kind == VMR_RSP_UNDEF)
    else $error("register reachable with highest index zero");

  a_index_reports_max:
    assert property ($past(rst_n) |-> highest_vmap_index == VMAP_MAX)
    else $error("highest index does not report the implemented maximum");

  a_trap_class_value:
    assert property (rsp.kind == VMR_RSP_TRAP |-> rsp.trap_class == 6'h18 &&
                     (rsp.target == VMR_LVL_HYP || rsp.target == VMR_LVL_MONITOR))
    else $error("trap response malformed");

  a_save_from_kernel:
    assert property (rsp.kind == VMR_RSP_SAVE |-> rsp.target == VMR_LVL_KERNEL &&
                     rsp.rdata == 64'h0)
    else $error("save area redirection malformed");

  a_hyp_direct_done:
    assert property (req.valid && acc_hit && acc_present && req.level == VMR_LVL_HYP &&
                     !monitor_traps |=> rsp.kind == VMR_RSP_DONE && rsp.target == VMR_LVL_HYP)
    else $error("hypervisor access not performed");

  a_write_lands:
    assert property (req.valid && acc_hit && acc_do_reg && req.write
                     |=> vmap_q[$past(acc_idx)] == $past(req.wdata))
    else $error("permitted write not stored");

  a_xl_strobe_follows:
    assert property (xl_valid |=> xl_out_valid)
    else $error("translation strobe missing");

  a_xl_idle_quiet:
    assert property (!xl_valid |=> !xl_out_valid && !xl_mapped)
    else $error("translation result without a request");

  a_entry28_field:
    assert property (xl_valid && xl_vid == 16'h001C && lk_enable && vmap_valid_bits[28] &&
                     vmap_max_q == 3'h7 |=> xl_mapped && xl_pid == $past(vmap_q[2][15:0]))
    else $error("entry 28 not taken from register 7 low field");

  a_out_of_range_pass:
    assert property (xl_valid && (xl_vid < 16'h0014 || xl_vid > 16'h001F)
                     |=> !xl_mapped && xl_pid == $past(xl_vid))
    else $error("id outside 20 to 31 was mapped");

endmodule : vmr_vmap_regs

// File: dv/tb_vmr_vmap_regs.sv
// Self-checking testbench for the virtual partition map registers 5 to 7
`timescale 1ns/1ps
module tb_vmr_vmap_regs;
  import vmr_pkg::*;

  // ****************************************************************
  // Signals, next-cycle stimulus and pending expectations
  // ****************************************************************
  logic clk, rst_n, kernel_vmap_enable, user_vmap_enable, xl_valid, xl_from_user;
  vmr_req_t req;
  vmr_ctrl_t ctrl;
  logic [VMR_VALID_W-1:0] vmap_valid_bits;
  logic [VMR_VID_W-1:0] xl_vid, xl_pid;
  vmr_rsp_t rsp, rsp_s, rsp_z;
  logic [2:0] hvi, hvi_s, hvi_z;
  logic xl_out_valid, xl_mapped;
  integer err_count, checks, seed, i, j;
  logic [31:0] rv;
  vmr_req_t nr;
  vmr_ctrl_t nc;
  logic nrst, nke, nue, nxv, nxu;
  logic [31:0] nvb;
  logic [15:0] nvid;
  vmr_rsp_t e_rsp, e_rsp_s, e_rsp_z;
  logic e_xv;
  logic [16:0] e_xl;
  logic [63:0] sh [3];
  logic [63:0] sh_s [3];

  // Full-size instance and one with only register 5 present
  vmr_vmap_regs #(.VMAP_MAX(3'h7)) uut (.clk(clk), .rst_n(rst_n), .req(req), .ctrl(ctrl),
    .kernel_vmap_enable(kernel_vmap_enable), .user_vmap_enable(user_vmap_enable),
    .vmap_valid_bits(vmap_valid_bits), .xl_valid(xl_valid), .xl_from_user(xl_from_user),
    .xl_vid(xl_vid), .rsp(rsp), .highest_vmap_index(hvi), .xl_out_valid(xl_out_valid),
    .xl_mapped(xl_mapped), .xl_pid(xl_pid));
  vmr_vmap_regs #(.VMAP_MAX(3'h5)) uut_small (.clk(clk), .rst_n(rst_n), .req(req),
    .ctrl(ctrl), .kernel_vmap_enable(kernel_vmap_enable), .user_vmap_enable(user_vmap_enable),
    .vmap_valid_bits(vmap_valid_bits), .xl_valid(xl_valid), .xl_from_user(xl_from_user),
    .xl_vid(xl_vid), .rsp(rsp_s), .highest_vmap_index(hvi_s), .xl_out_valid(),
    .xl_mapped(), .xl_pid());
  // Highest index zero: none of registers 5 to 7 may be reachable
  vmr_vmap_regs #(.VMAP_MAX(3'h0)) uut_none (.clk(clk), .rst_n(rst_n), .req(req),
    .ctrl(ctrl), .kernel_vmap_enable(kernel_vmap_enable), .user_vmap_enable(user_vmap_enable),
    .vmap_valid_bits(vmap_valid_bits), .xl_valid(xl_valid), .xl_from_user(xl_from_user),
    .xl_vid(xl_vid), .rsp(rsp_z), .highest_vmap_index(hvi_z), .xl_out_valid(),
    .xl_mapped(), .xl_pid());

  // 10 MHz core clock
  always #50 clk = ~clk;

  // ****************************************************************
  // Expectation functions
  // ****************************************************************
  // Access outcome in the documented decision order; absent registers win over every level
  function automatic vmr_rsp_t exp_access(vmr_req_t r, vmr_ctrl_t c, logic [2:0] mx,
                                          logic [63:0] cur);
    vmr_rsp_t e;
    logic hit;
    logic tl;
    e = '0;
    tl = c.monitor_present && c.trap_lower_levels;
    hit = r.enc.op0 == VMR_ENC_OP0 && r.enc.op1 == VMR_ENC_OP1 && r.enc.crn == VMR_ENC_CRN &&
          r.enc.crm == VMR_ENC_CRM && r.enc.op2 >= 3'h5;
    if (!(r.valid && hit)) return e;
    e.valid = 1'b1;
    e.write = r.write;
    e.target = r.level;
    e.kind = VMR_RSP_UNDEF;
    if (!(c.partitioning_present && c.has_hyp_control && mx >= r.enc.op2)) return e;
    if (r.level == VMR_LVL_KERNEL && c.el2_enabled && c.nested_virt && c.nested_virt_mem) begin
      e.kind = VMR_RSP_SAVE;
      e.save_offset = 12'h968 + 12'(8 * (r.enc.op2 - 3'h5));
    end else if ((r.level == VMR_LVL_KERNEL && c.el2_enabled && c.nested_virt) ||
                 (r.level == VMR_LVL_HYP && tl)) begin
      e.kind = VMR_RSP_TRAP;
      e.trap_class = 6'h18;
      e.target = tl ? VMR_LVL_MONITOR : VMR_LVL_HYP;
    end else if (r.level == VMR_LVL_HYP || r.level == VMR_LVL_MONITOR) begin
      e.kind = VMR_RSP_DONE;
      if (!r.write) e.rdata = cur;
    end
    return e;
  endfunction : exp_access

  // Translation result as {mapped, id}; ids outside 20 to 31 pass through
  function automatic logic [16:0] exp_map(vmr_ctrl_t c, logic fu, logic ke, logic ue,
                                          logic [31:0] vb, logic [15:0] vid);
    logic ok;
    ok = c.el2_enabled && c.partitioning_present && c.has_hyp_control && (fu ? ue : ke) &&
         vid >= 16'h14 && vid <= 16'h1F && vb[vid[4:0]];
    return ok ? {1'b1, sh[vid[4:2] - 3'h5][16 * vid[1:0] +: 16]} : {1'b0, vid};
  endfunction : exp_map

  // ****************************************************************
  // Checking and driving tasks
  // ****************************************************************
  task automatic chk(logic ok, string msg);
    checks = checks + 1;
    if (ok !== 1'b1) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // One clock: drive the next stimulus, check last cycle's answers, then predict this one.
  // Predicting after the drive keeps back-to-back traffic free of gaps.
  task automatic step();
    vmr_rsp_t er;
    vmr_rsp_t ers;
    @(posedge clk);
    rst_n <= nrst;
    req <= nr;
    ctrl <= nc;
    kernel_vmap_enable <= nke;
    user_vmap_enable <= nue;
    vmap_valid_bits <= nvb;
    xl_valid <= nxv;
    xl_from_user <= nxu;
    xl_vid <= nvid;
    #1;
    chk(rsp === e_rsp, "access response");
    chk(rsp_s === e_rsp_s, "access response, reduced instance");
    chk(rsp_z === e_rsp_z, "access response, zero-index instance");
    chk(xl_out_valid === e_xv, "translation strobe");
    if (e_xv) chk({xl_mapped, xl_pid} === e_xl, "translation result");
    er = nrst ? exp_access(nr, nc, 3'h7, sh[nr.enc.op2 - 3'h5]) : '0;
    ers = nrst ? exp_access(nr, nc, 3'h5, sh_s[nr.enc.op2 - 3'h5]) : '0;
    e_xv = nxv && nrst;
    e_xl = exp_map(nc, nxu, nke, nue, nvb, nvid);
    // Storage moves only on a completed write; the lookup above saw the old value
    if (er.kind == VMR_RSP_DONE && nr.write) sh[nr.enc.op2 - 3'h5] = nr.wdata;
    if (ers.kind == VMR_RSP_DONE && nr.write) sh_s[nr.enc.op2 - 3'h5] = nr.wdata;
    e_rsp = er;
    e_rsp_s = ers;
    e_rsp_z = nrst ? exp_access(nr, nc, 3'h0, 64'h0) : '0;
  endtask : step

  task automatic final_report();
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    ctrl = '0;
    {kernel_vmap_enable, user_vmap_enable, xl_valid, xl_from_user} = 4'h0;
    vmap_valid_bits = '0;
    xl_vid = '0;
    {nrst, nke, nue, nxv, nxu} = 5'h0;
    nr = '0;
    nc = '0;
    nvb = '0;
    nvid = '0;
    e_rsp = '0;
    e_rsp_s = '0;
    e_rsp_z = '0;
    e_xv = 1'b0;
    e_xl = '0;
    err_count = 0;
    checks = 0;
    seed = 58;
    // Reset for 12 cycles, then two quiet cycles before the first request
    repeat (12) step();
    chk(hvi === 3'h7, "index during reset");
    nrst = 1'b1;
    repeat (2) step();
    chk(hvi === 3'h7, "highest index");
    chk(hvi_s === 3'h5, "highest index, reduced instance");
    chk(hvi_z === 3'h0, "highest index, zero-index instance");
    // Monitor writes to 5, 6, 7 then reads back to back; each entry holds 0xA000 plus its id
    nc = vmr_ctrl_t'(7'h7F);
    nr.level = VMR_LVL_MONITOR;
    nr.enc = '{VMR_ENC_OP0, VMR_ENC_OP1, VMR_ENC_CRN, VMR_ENC_CRM, VMR_ENC_OP2_REG5};
    for (i = 0; i < 6; i++) begin
      nr.valid = 1'b1;
      nr.write = i < 3;
      nr.enc.op2 = 3'h5 + 3'(i % 3);
      for (j = 0; j < 4; j++) nr.wdata[16 * j +: 16] = 16'hA014 + 16'(4 * (i % 3) + j);
      step();
    end
    // Walk ids 18 to 33 from both sources; entry 31 is left unvalidated
    nr.valid = 1'b0;
    {nke, nue, nxv} = 3'h7;
    nvb = 32'h7FFF_FFFF;
    for (i = 18; i < 34; i++) begin
      nxu = i[0];
      nvid = 16'(i);
      step();
    end
    // Random traffic, mostly matching encodings with every level and control mix
    for (i = 0; i < 400; i++) begin
      rv = $random(seed);
      nr.valid = rv[1:0] != 2'h0;
      nr.write = rv[2];
      nr.level = vmr_level_t'(rv[4:3]);
      nr.enc.crm = (rv[7:5] == 3'h0) ? rv[11:8] : VMR_ENC_CRM;
      nr.enc.op2 = (rv[13:12] == 2'h3) ? 3'h7 : 3'h5 + {1'b0, rv[13:12]};
      nr.wdata = {$random(seed), $random(seed)};
      nc = vmr_ctrl_t'(rv[20:14]);
      if (rv[21]) {nc.partitioning_present, nc.has_hyp_control} = 2'h3;
      {nke, nue, nxv, nxu} = rv[25:22];
      nvid = 16'h12 + {12'h0, rv[31:28]};
      nvb = $random(seed);
      step();
    end
    // Drain the last answers
    nr.valid = 1'b0;
    nxv = 1'b0;
    repeat (2) step();
    final_report();
  end

endmodule : tb_vmr_vmap_regs

// File: shared/vmr_pkg.sv
// Shared constants and carrier types for the virtual partition map registers 5 to 7
package vmr_pkg;

  // ****************************************************************
  // Access encoding
  // ****************************************************************
  localparam logic [1:0] VMR_ENC_OP0 = 2'h3;
  localparam logic [2:0] VMR_ENC_OP1 = 3'h4;
  localparam logic [3:0] VMR_ENC_CRN = 4'hA;
  localparam logic [3:0] VMR_ENC_CRM = 4'h6;
  localparam logic [2:0] VMR_ENC_OP2_REG5 = 3'h5;
  localparam logic [2:0] VMR_ENC_OP2_REG6 = 3'h6;
  localparam logic [2:0] VMR_ENC_OP2_REG7 = 3'h7;

  // ****************************************************************
  // Layout, presence and redirection constants
  // ****************************************************************
  localparam int VMR_NUM_REGS = 3;
  localparam int VMR_FIRST_REG = 5;
  localparam int VMR_ENTRY_W = 16;
  localparam int VMR_ENTRIES_PER_REG = 4;
  localparam int VMR_REG_W = 64;
  localparam int VMR_VID_W = 16;
  localparam int VMR_VALID_W = 32;
  localparam logic [2:0] VMR_VMAP_MAX_RESET = 3'h7;
  localparam logic [11:0] VMR_SAVE_OFS_REG5 = 12'h968;
  localparam logic [11:0] VMR_SAVE_OFS_REG6 = 12'h970;
  localparam logic [11:0] VMR_SAVE_OFS_REG7 = 12'h978;
  localparam logic [5:0] VMR_TRAP_CLASS = 6'h18;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    VMR_LVL_USER = 2'h0,
    VMR_LVL_KERNEL = 2'h1,
    VMR_LVL_HYP = 2'h2,
    VMR_LVL_MONITOR = 2'h3
  } vmr_level_t;

  typedef enum logic [3:0] {
    VMR_RSP_DONE = 4'h1,
    VMR_RSP_UNDEF = 4'h2,
    VMR_RSP_TRAP = 4'h4,
    VMR_RSP_SAVE = 4'h8
  } vmr_rsp_kind_t;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } vmr_enc_t;

  typedef struct packed {
    logic valid;
    logic write;
    vmr_enc_t enc;
    vmr_level_t level;
    logic [63:0] wdata;
  } vmr_req_t;

  typedef struct packed {
    logic el2_enabled;
    logic nested_virt;
    logic nested_virt_mem;
    logic monitor_present;
    logic trap_lower_levels;
    logic partitioning_present;
    logic has_hyp_control;
  } vmr_ctrl_t;

  typedef struct packed {
    logic valid;
    logic write;
    vmr_rsp_kind_t kind;
    vmr_level_t target;
    logic [5:0] trap_class;
    logic [11:0] save_offset;
    logic [63:0] rdata;
  } vmr_rsp_t;

endpackage : vmr_pkg
